// ==== verilog/asr_pkg.sv ====
// constants and types of the converter sequencer and result store
package asr_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [11:0] ADDR_RES_BASE = 12'h2a0;
   localparam logic [11:0] ADDR_CTRL_A   = 12'h2b0;
   localparam logic [11:0] ADDR_CTRL_B   = 12'h2b1;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h2b2;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h2b3;

   // ****************************************
   // field positions
   // ****************************************
   localparam int A_START = 0;
   localparam int A_SCAN  = 3;
   localparam int A_REP   = 4;
   localparam int A_ITM   = 5;
   localparam int A_BUSY  = 6;
   localparam int A_DONE  = 7;
   localparam int B_SEL   = 0;
   localparam int B_TRGEN = 5;
   localparam int B_SRE   = 6;

   // ****************************************
   // reset values and timing
   // ****************************************
   localparam logic [7:0] RST_RDATA    = 8'h00;
   localparam logic [2:0] RST_SEL      = 3'h0;
   localparam int         RES_W        = 10;
   localparam int         CONV_STATES  = 84;
   localparam int         STATE_CYCLES = 1;
   localparam logic [6:0] CONV_LAST    =
      7'(CONV_STATES * STATE_CYCLES - 1);
   localparam logic [1:0] IRQ_EVERY    = 2'h3;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_HALT = 3'b100
   } asr_fsm_t;

   typedef struct packed
   {
      asr_fsm_t               fsm;
      logic [6:0]             cnt;
      logic [2:0]             chan;
      logic [1:0]             rot;
      logic [1:0]             icnt;
      logic                   rep_run;
      logic                   trig_prev;
      logic                   done;
      logic                   itm;
      logic                   rep;
      logic                   scan;
      logic                   sre;
      logic                   trg_en;
      logic [2:0]             sel;
      logic [3:0][RES_W-1:0]  res;
      logic [3:0]             flag;
      logic                   irq_stat;
      logic                   irq_mask;
      logic                   irq;
      logic [7:0]             rdata;
   } asr_state_t;

endpackage

// ==== verilog/asr_seq.sv ====
// sequencer, mode control and result store of the 8-input converter
//
// Behaviour
// (R1) scan repeat: rescan forever, set done and irq per scan, busy stays
// (R2) repeat cleared: finish current conversion, then stop, busy 0
// (R3) light standby without run enable, deep idle, stop: halt at once
// (R4) halt released in repeat mode: restart from sequence start
// (R5) halt released in single mode: stay stopped
// (R6) one conversion takes 84 peripheral states
// (R7) result pairs are read-only; writes ignored
// (R8) fixed repeat with interval 1: results rotate pairs 0,1,2,3
// (R9) otherwise channel n and n+4 store into pair n
// (R10) storing a result sets that pair's stored flag, bit 0 low byte
// (R11) reading either byte of a pair clears its stored flag
// (R12) reading any result clears the done flag
// (R13) fixed repeat: irq every conversion, or every fourth with interval 1
// (R14) start bit or enabled trigger falling edge starts; busy set
// (R15) trigger falling edge during conversion is ignored
// (R16) start bit during conversion aborts and restarts
// (R17) scan: select 0-3 scans from 0, select 4-7 scans from 4
// (R18) single mode end: set done, clear busy, one irq
`timescale 1ns/1ps

module asr_seq
   import asr_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [11:0]      addr,
   input  wire logic [7:0]       wdata,
   input  wire logic             wr_en,
   input  wire logic             rd_en,
   output logic      [7:0]       rdata,
   output logic                  conv_end_irq,
   input  wire logic             ext_trigger_pin,
   input  wire logic             light_standby,
   input  wire logic             deep_idle,
   input  wire logic             stop_mode,
   input  wire logic [RES_W-1:0] adc_sample,
   output logic      [2:0]       input_select,
   output logic                  sample_active
);

   // ****************************************
   // decode and events
   // ****************************************
   asr_state_t s_q;
   asr_state_t s_d;
   logic       halt;
   logic       fall;
   logic       start_wr;
   logic       start_req;
   logic       comp;
   logic       res_hit;
   logic       res_rd;
   logic [1:0] wpair;
   logic       last_chan;

   assign halt      = (light_standby & ~s_q.sre) | deep_idle | stop_mode;
   assign fall      = s_q.trig_prev & ~ext_trigger_pin;
   assign start_wr  = wr_en & (addr == ADDR_CTRL_A) & wdata[A_START];
   assign start_req = start_wr | (s_q.trg_en & fall); // see (R14)
   assign comp      = (s_q.fsm == ST_CONV) & ~halt & ~start_wr
                      & (s_q.cnt == CONV_LAST); // see (R6)
   assign res_hit   = addr[11:3] == ADDR_RES_BASE[11:3];
   assign res_rd    = rd_en & res_hit;
   // rotation only for fixed repeat with interval 1
   assign wpair     = (s_q.rep_run & ~s_q.scan & s_q.itm) ?
                      s_q.rot : s_q.chan[1:0]; // see (R8) see (R9)
   assign last_chan = s_q.chan[1:0] == s_q.sel[1:0];

   // first channel of a sequence; repeat mode latched here
   function automatic asr_state_t seq_start(input asr_state_t st);
      asr_state_t r;
      r         = st;
      r.fsm     = ST_CONV;
      r.cnt     = 7'h00;
      r.chan    = st.scan ? {st.sel[2], 2'b00} : st.sel; // see (R17)
      r.rot     = 2'h0;
      r.icnt    = 2'h0;
      r.rep_run = st.rep;
      return r;
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      s_d           = s_q;
      s_d.rdata     = RST_RDATA;
      s_d.trig_prev = ext_trigger_pin;

      if (wr_en)
      begin
         unique case (addr)
            ADDR_CTRL_A:
            begin
               s_d.itm  = wdata[A_ITM];
               s_d.rep  = wdata[A_REP];
               s_d.scan = wdata[A_SCAN];
            end
            ADDR_CTRL_B:
            begin
               s_d.sre    = wdata[B_SRE];
               s_d.trg_en = wdata[B_TRGEN];
               s_d.sel    = wdata[B_SEL +: 3];
            end
            ADDR_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~wdata[0];
            ADDR_IRQ_MASK: s_d.irq_mask = wdata[0];
            default: ; // result pairs take no writes, see (R7)
         endcase
      end

      if (rd_en)
      begin
         if (res_hit)
         begin
            s_d.flag[addr[2:1]] = 1'b0; // see (R11)
            s_d.done            = 1'b0; // see (R12)
            if (addr[0])
               s_d.rdata = s_q.res[addr[2:1]][RES_W-1:2];
            else
               s_d.rdata = {s_q.res[addr[2:1]][1:0], 5'h1f,
                            s_q.flag[addr[2:1]]};
         end
         else
         begin
            unique case (addr)
               ADDR_CTRL_A:   s_d.rdata = {s_q.done,
                                  s_q.fsm != ST_IDLE, s_q.itm, s_q.rep,
                                  s_q.scan, 3'h0};
               ADDR_CTRL_B:   s_d.rdata = {1'b0, s_q.sre, s_q.trg_en,
                                  2'h0, s_q.sel};
               ADDR_IRQ_STAT: s_d.rdata = {7'h00, s_q.irq_stat};
               ADDR_IRQ_MASK: s_d.rdata = {7'h00, s_q.irq_mask};
               default:       s_d.rdata = RST_RDATA;
            endcase
         end
      end

      unique case (s_q.fsm)
         ST_IDLE:
         begin
            // a halted converter takes no start
            if (start_req & ~halt)
               s_d = seq_start(s_d); // see (R14)
         end
         ST_CONV:
         begin
            if (halt)
               // only repeat work survives the halt; see (R3) see (R5)
               s_d.fsm = s_q.rep_run ? ST_HALT : ST_IDLE;
            else if (start_wr)
               s_d = seq_start(s_d); // see (R16)
            else if (comp)
            begin
               s_d.res[wpair]  = adc_sample;
               s_d.flag[wpair] = 1'b1; // set beats read clear, see (R10)
               s_d.done        = 1'b1;
               s_d.cnt         = 7'h00;
               if (s_q.rep_run & ~s_q.rep)
                  s_d.fsm = ST_IDLE; // see (R2)
               else if (s_q.scan)
               begin
                  if (!last_chan)
                  begin
                     s_d.done = s_q.done & ~res_rd;
                     s_d.chan = s_q.chan + 3'h1;
                  end
                  else
                  begin
                     s_d.irq_stat = 1'b1; // see (R1) see (R18)
                     if (s_q.rep_run)
                        s_d.chan = {s_q.sel[2], 2'b00}; // see (R1)
                     else
                        s_d.fsm = ST_IDLE; // see (R18)
                  end
               end
               else if (s_q.rep_run)
               begin
                  s_d.rot  = s_q.rot + 2'h1; // see (R8)
                  s_d.icnt = s_q.icnt + 2'h1;
                  if (!s_q.itm | (s_q.icnt == IRQ_EVERY))
                     s_d.irq_stat = 1'b1; // see (R13)
               end
               else
               begin
                  s_d.irq_stat = 1'b1; // see (R18)
                  s_d.fsm      = ST_IDLE;
               end
            end
            else
               s_d.cnt = s_q.cnt + 7'h01; // trigger ignored, see (R15)
         end
         ST_HALT:
         begin
            if (!halt)
            begin
               if (s_q.rep)
                  s_d = seq_start(s_d); // see (R4)
               else
                  s_d.fsm = ST_IDLE; // see (R5)
            end
         end
      endcase

      s_d.irq = s_d.irq_stat & s_d.irq_mask;
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q      <= '0;
         s_q.fsm  <= ST_IDLE;
         s_q.sel  <= RST_SEL;
      end
      else
         s_q <= s_d;
   end

   assign rdata         = s_q.rdata;
   assign conv_end_irq  = s_q.irq;
   assign input_select  = s_q.chan;
   assign sample_active = s_q.fsm[1];

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_start_busy: assert property ( // see (R14)
      (s_q.fsm == ST_IDLE) && start_wr && !halt |=>
      (s_q.fsm == ST_CONV) && (s_q.cnt == 7'h00))
      else $error("start did not begin a conversion");

   a_trig_ignored: assert property ( // see (R15)
      (s_q.fsm == ST_CONV) && fall && !start_wr && !halt && !comp |=>
      (s_q.cnt == $past(s_q.cnt) + 7'h01))
      else $error("trigger disturbed a running conversion");

   a_conv_length: assert property ( // see (R6)
      comp |-> ($past(s_q.cnt, 83) == 7'h00) &&
      ($past(s_q.fsm, 83) == ST_CONV))
      else $error("conversion length is not 84 states");

   a_halt_stops: assert property ( // see (R3)
      (s_q.fsm == ST_CONV) && halt |=> (s_q.fsm != ST_CONV))
      else $error("halt did not stop the converter");

   a_single_halt: assert property ( // see (R5)
      (s_q.fsm == ST_CONV) && halt && !s_q.rep_run |=>
      (s_q.fsm == ST_IDLE) [*2])
      else $error("single mode resumed after halt");

   a_repeat_resume: assert property ( // see (R4)
      (s_q.fsm == ST_HALT) && !halt && s_q.rep |=>
      (s_q.fsm == ST_CONV) && (s_q.cnt == 7'h00) && (s_q.rot == 2'h0))
      else $error("repeat did not restart after halt");

   // done waits for the end of a scan, unless repeat was just cleared
   a_flag_set: assert property ( // see (R10)
      comp |=> s_q.flag[$past(wpair)] &&
      (s_q.done || $past(s_q.scan && !last_chan &&
      !(s_q.rep_run && !s_q.rep))) &&
      (s_q.res[$past(wpair)] == $past(adc_sample)))
      else $error("stored result or flag missing");

   a_read_clear: assert property ( // see (R11)
      res_rd && !comp |=> !s_q.flag[$past(addr[2:1])] && !s_q.done)
      else $error("result read did not clear flags");

   a_result_ro: assert property ( // see (R7)
      wr_en && res_hit && !comp |=> $stable(s_q.res))
      else $error("write changed a result pair");

   a_scan_busy: assert property ( // see (R1)
      comp && s_q.scan && s_q.rep_run && s_q.rep |=>
      (s_q.fsm == ST_CONV))
      else $error("scan repeat dropped busy");

   a_repeat_stop: assert property ( // see (R2)
      comp && s_q.rep_run && !s_q.rep |=> (s_q.fsm == ST_IDLE))
      else $error("repeat did not stop after clear");

   a_fourth_irq: assert property ( // see (R13)
      comp && s_q.rep_run && s_q.rep && !s_q.scan && s_q.itm &&
      (s_q.icnt != IRQ_EVERY) && !s_q.irq_stat && !wr_en |=>
      !s_q.irq_stat)
      else $error("interrupt before fourth conversion");

   a_single_end: assert property ( // see (R18)
      comp && !s_q.rep_run && !s_q.scan |=>
      (s_q.fsm == ST_IDLE) && s_q.irq_stat && s_q.done)
      else $error("single conversion end incomplete");

   c_scan_repeat: cover property (comp && s_q.scan && s_q.rep_run);
   c_rotation:    cover property (comp && s_q.itm && s_q.rot == 2'h3);
   c_halt_resume: cover property ((s_q.fsm == ST_HALT) ##1 !halt);
   c_restart:     cover property ((s_q.fsm == ST_CONV) && start_wr);

endmodule // asr_seq

// ==== verif/asr_analog_model.sv ====
// model of the eight multiplexed analog inputs feeding the converter
`timescale 1ns/1ps

module asr_analog_model
   import asr_pkg::*;
(
   input  wire logic [2:0]       input_select,
   input  wire logic             sample_active,
   output logic      [RES_W-1:0] adc_sample
);
   // each channel has its own level; an idle mux shows the inverse so
   // a capture outside a conversion is caught
   assign adc_sample = sample_active ? {input_select, 7'h2a}
                                     : ~{input_select, 7'h2a};
endmodule // asr_analog_model

// ==== verif/test_adc_sequencer_result_store.sv ====
// self-checking bench of the converter sequencer and result store
`timescale 1ns/1ps

module test_adc_sequencer_result_store
   import asr_pkg::*;
;
   logic             clock;
   logic             rst_n;
   logic [11:0]      addr;
   logic [7:0]       wdata;
   logic             wr_en;
   logic             rd_en;
   logic [7:0]       rdata;
   logic             conv_end_irq;
   logic             ext_trigger_pin;
   logic             light_standby;
   logic             deep_idle;
   logic             stop_mode;
   logic [RES_W-1:0] adc_sample;
   logic [2:0]       input_select;
   logic             sample_active;
   logic [7:0]       v;
   int               fail_count;
   int               checked;
   int               n;

   asr_seq DUT (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .conv_end_irq(conv_end_irq), .ext_trigger_pin(ext_trigger_pin),
      .light_standby(light_standby), .deep_idle(deep_idle),
      .stop_mode(stop_mode), .adc_sample(adc_sample),
      .input_select(input_select), .sample_active(sample_active));

   asr_analog_model u_model (.input_select(input_select),
      .sample_active(sample_active), .adc_sample(adc_sample));

   always #12.5 clock = ~clock;

   // ****************************************
   // bus and check tasks
   // ****************************************
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask

   task rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clock);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask

   task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // bounded so a missing interrupt cannot hang the run
   task wirq(output int c);
      c = 0;
      do
      begin
         @(posedge clock);
         c++;
         #1;
      end while (conv_end_irq !== 1'b1 && c < 1000);
   endtask

   task conv(input logic [7:0] a, output int c);
      wr(ADDR_CTRL_A, a);
      wirq(c);
      wr(ADDR_IRQ_STAT, 8'h01);
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   function automatic logic [7:0] hi(input logic [2:0] c);
      return {c, 5'h0a};
   endfunction

   initial
   begin
      repeat (20000) @(posedge clock);
      fail_count++;
      test_done;
   end

   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      clock           = 1'b0;
      rst_n           = 1'b0;
      addr            = 12'h000;
      wdata           = 8'h00;
      wr_en           = 1'b0;
      rd_en           = 1'b0;
      ext_trigger_pin = 1'b0;
      light_standby   = 1'b0;
      deep_idle       = 1'b0;
      stop_mode       = 1'b0;
      fail_count      = 0;
      checked         = 0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      rd(ADDR_CTRL_A, v);
      chk("ctrl_a reset", 10'h000, {2'h0, v});
      rd(ADDR_RES_BASE, v);
      chk("pair0 low reset", 10'h03e, {2'h0, v});
      rd(12'h2c0, v);
      chk("unmapped", 10'h000, {2'h0, v});
      wr(ADDR_IRQ_MASK, 8'h01);
      for (int c = 0; c < 8; c++)
      begin
         wr(ADDR_CTRL_B, 8'(c));
         conv(8'h01, n);
         chk("conv cycles", 10'h054, 10'(n));
         rd(ADDR_CTRL_A, v);
         chk("done busy", 10'h080, {2'h0, v & 8'hc0});
         rd(ADDR_RES_BASE + 12'(2 * (c % 4)), v);
         chk("low flag set", 10'h0bf, {2'h0, v});
         rd(ADDR_RES_BASE + 12'(2 * (c % 4) + 1), v);
         chk("high by chan", 10'(hi(3'(c))), {2'h0, v});
         rd(ADDR_RES_BASE + 12'(2 * (c % 4)), v);
         chk("flag cleared", 10'h0be, {2'h0, v});
         rd(ADDR_CTRL_A, v);
         chk("done cleared", 10'h000, {2'h0, v & 8'h80});
      end
      $display("test fixed single done");
      wr(ADDR_RES_BASE + 12'h001, 8'h00);
      rd(ADDR_RES_BASE + 12'h001, v);
      chk("pair0 read only", 10'(hi(3'h4)), {2'h0, v});
      wr(ADDR_IRQ_MASK, 8'h00);
      wr(ADDR_CTRL_A, 8'h01);
      repeat (90) @(posedge clock);
      chk("masked irq", 10'h000, {9'h0, conv_end_irq});
      wr(ADDR_IRQ_MASK, 8'h01);
      @(posedge clock);
      #1 chk("unmasked irq", 10'h001, {9'h0, conv_end_irq});
      wr(ADDR_IRQ_STAT, 8'h01);
      @(posedge clock);
      #1 chk("irq cleared", 10'h000, {9'h0, conv_end_irq});
      $display("test interrupt done");
      wr(ADDR_CTRL_B, 8'h06);
      conv(8'h09, n);
      chk("scan cycles", 10'h0fc, 10'(n));
      for (int p = 0; p < 3; p++)
      begin
         rd(ADDR_RES_BASE + 12'(2 * p + 1), v);
         chk("scan result", 10'(hi(3'(p + 4))), {2'h0, v});
      end
      $display("test scan single done");
      wr(ADDR_CTRL_B, 8'h01);
      for (int t = 0; t < 2; t++)
      begin
         conv(t ? 8'h31 : 8'h11, n);
         chk("repeat irq", t ? 10'h150 : 10'h054, 10'(n));
      end
      for (int p = 0; p < 4; p++)
      begin
         rd(ADDR_RES_BASE + 12'(2 * p + 1), v);
         chk("rotation", 10'(hi(3'h1)), {2'h0, v});
      end
      wr(ADDR_CTRL_A, 8'h20);
      rd(ADDR_CTRL_A, v);
      chk("busy on stop", 10'h040, {2'h0, v & 8'h40});
      repeat (90) @(posedge clock);
      rd(ADDR_CTRL_A, v);
      chk("busy after stop", 10'h000, {2'h0, v & 8'h40});
      wr(ADDR_IRQ_STAT, 8'h01);
      $display("test fixed repeat done");
      conv(8'h19, n);
      chk("scan repeat", 10'h0a8, 10'(n));
      rd(ADDR_CTRL_A, v);
      chk("scan rep flags", 10'h0c0, {2'h0, v & 8'hc0});
      wr(ADDR_CTRL_A, 8'h00);
      repeat (200) @(posedge clock);
      wr(ADDR_IRQ_STAT, 8'h01);
      $display("test scan repeat done");
      wr(ADDR_CTRL_B, 8'h22);
      @(posedge clock) ext_trigger_pin <= 1'b1;
      @(posedge clock) ext_trigger_pin <= 1'b0;
      repeat (30) @(posedge clock);
      ext_trigger_pin <= 1'b1;
      @(posedge clock) ext_trigger_pin <= 1'b0;
      wirq(n);
      chk("trigger", 10'h001, 10'(n >= 52 && n <= 56));
      wr(ADDR_IRQ_STAT, 8'h01);
      wr(ADDR_CTRL_A, 8'h01);
      repeat (40) @(posedge clock);
      conv(8'h01, n);
      chk("restart", 10'h054, 10'(n));
      $display("test trigger restart done");
      for (int j = 0; j < 3; j++)
      begin
         wr(ADDR_CTRL_A, 8'h01);
         repeat (20) @(posedge clock);
         {light_standby, deep_idle, stop_mode} <= 3'(1 << j);
         repeat (10) @(posedge clock);
         {light_standby, deep_idle, stop_mode} <= 3'h0;
         repeat (100) @(posedge clock);
         rd(ADDR_CTRL_A, v);
         chk("halt busy", 10'h000, {2'h0, v & 8'h40});
         chk("halt irq", 10'h000, {9'h0, conv_end_irq});
      end
      wr(ADDR_CTRL_A, 8'h11);
      repeat (20) @(posedge clock);
      stop_mode <= 1'b1;
      repeat (10) @(posedge clock);
      stop_mode <= 1'b0;
      wirq(n);
      chk("halt restart", 10'h001, 10'(n >= 84 && n <= 86));
      wr(ADDR_CTRL_A, 8'h00);
      repeat (90) @(posedge clock);
      $display("test halt done");
      test_done;
   end
endmodule // test_adc_sequencer_result_store
